/* File: rtl/rtdc_defs.svh */
// Constants for the RS-485 transceiver direction control block.
// Assumes inclusion by bare name from design files only.
`ifndef RTDC_DEFS_SVH
`define RTDC_DEFS_SVH

`define RTDC_SCRATCH_OFFSET 3'h7
`define RTDC_MODE_FOUR_WIRE 8'h00
`define RTDC_MODE_ECHO      8'h01
`define RTDC_MODE_CTRL      8'h02
`define RTDC_MODE_AUTO      8'h03
`define RTDC_FIFO_DEPTH     16
`define RTDC_PTR_W          4
`define RTDC_CNT_W          5
`define RTDC_CNT_ZERO       5'h00
`define RTDC_CNT_ONE        5'h01
`define RTDC_PTR_ONE        4'h1
`define RTDC_BYTE_ZERO      8'h00

`endif

/* File: rtl/rtdc_fifo.sv */
// Byte FIFO used for the transmit and receive paths of one port.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "rtdc_defs.svh"

module rtdc_fifo (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       enable,
   input  wire logic       in_valid,
   output logic            in_ready,
   input  wire logic [7:0] in_data,
   output logic            out_valid,
   input  wire logic       out_ready,
   output logic [7:0]      out_data,
   output logic [4:0]      level
);

   rtdc_pkg::rtdc_fifo_s st_r;
   rtdc_pkg::rtdc_fifo_s st_nxt;
   logic                 push;
   logic                 pop;
   logic                 full;
   logic                 empty;

   // A disabled FIFO behaves as a single byte holding register, as the
   // UART does with its FIFOs turned off.
   assign full  = enable ? (st_r.count == 5'(`RTDC_FIFO_DEPTH))
                         : (st_r.count != `RTDC_CNT_ZERO);
   assign empty = (st_r.count == `RTDC_CNT_ZERO);
   assign push  = in_valid && !full;
   assign pop   = out_ready && !empty;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wr_ptr] = in_data;
         st_nxt.wr_ptr = st_r.wr_ptr + `RTDC_PTR_ONE;
      end
      if (pop) begin
         st_nxt.rd_ptr = st_r.rd_ptr + `RTDC_PTR_ONE;
      end
      if (push && !pop) begin
         st_nxt.count = st_r.count + `RTDC_CNT_ONE;
      end else if (pop && !push) begin
         st_nxt.count = st_r.count - `RTDC_CNT_ONE;
      end
      if (srst) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = st_r.mem[st_r.rd_ptr];
   assign level     = st_r.count;

   a_fifo_bound : assert property (@(posedge clk) disable iff (srst)
      st_r.count <= 5'(`RTDC_FIFO_DEPTH))
      else $error("fifo count beyond depth");

endmodule

/* File: rtl/rtdc_pkg.sv */
// Types for the RS-485 transceiver direction control block.
// Assumes the constants header is available to design files.
package rtdc_pkg;

   typedef enum logic [3:0] {
      RTDC_FOUR_WIRE = 4'b0001,
      RTDC_ECHO      = 4'b0010,
      RTDC_CTRL      = 4'b0100,
      RTDC_AUTO      = 4'b1000
   } rtdc_mode_e;

   typedef struct packed {
      logic [15:0][7:0] mem;
      logic [3:0]       wr_ptr;
      logic [3:0]       rd_ptr;
      logic [4:0]       count;
   } rtdc_fifo_s;

   typedef struct packed {
      rtdc_mode_e mode;
      logic [7:0] scratch;
      logic       tx_en;
      logic       rx_en;
   } rtdc_top_s;

endpackage

/* File: rtl/rtdc_top.sv */
// RS-485 direction control with the port's transmit and receive FIFOs.
// Assumes the UART shifter reports a frame in progress on tx_shifting.
// Notes on behaviour
// - Four modes steer line driver and receiver.
// - Four-wire keeps driver and receiver on.
// - Four-wire is the default mode.
// - Echo mode: driver on while ready high.
// - Echo mode keeps receiver always on.
// - Controlled mode: receiver off when driver on.
// - Automatic mode: slot-ready low enables driver.
// - Automatic mode: receiver off while driver on.
// - Ready and slot-ready are active low.
// - Separate transmit and receive FIFOs exist.
// - Software enables or disables each FIFO.
// - Scratch write at offset 7 sets mode.
// - Bytes 0 to 3 select the modes.
`timescale 1ns/1ps
`include "rtdc_defs.svh"

module rtdc_top (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       reg_wr,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       term_ready_n,
   input  wire logic       tx_fifo_en,
   input  wire logic       rx_fifo_en,
   input  wire logic       tx_in_valid,
   output logic            tx_in_ready,
   input  wire logic [7:0] tx_in_data,
   output logic            tx_out_valid,
   input  wire logic       tx_out_ready,
   output logic [7:0]      tx_out_data,
   input  wire logic       tx_shifting,
   input  wire logic       rx_in_valid,
   output logic            rx_in_ready,
   input  wire logic [7:0] rx_in_data,
   output logic            rx_out_valid,
   input  wire logic       rx_out_ready,
   output logic [7:0]      rx_out_data,
   output logic [4:0]      rx_level,
   output logic            transmit_slot_ready_n,
   output logic            line_tx_en,
   output logic            line_rx_en,
   output logic [7:0]      scratch_rdata,
   output logic [3:0]      mode_state
);

   rtdc_pkg::rtdc_top_s   st_r;
   rtdc_pkg::rtdc_top_s   st_nxt;
   rtdc_pkg::rtdc_mode_e  mode_now;
   logic                  tx_busy;
   logic                  slot_n;
   logic                  tx_drive;
   logic                  rx_open;
   logic                  rx_push_ok;
   logic                  tx_fifo_valid;
   logic                  rx_fifo_ready;

   // Decode of the mode byte; any unassigned value falls back to four-wire.
   function automatic rtdc_pkg::rtdc_mode_e decode_mode(input logic [7:0] b);
      unique case (b)
         `RTDC_MODE_ECHO: decode_mode = rtdc_pkg::RTDC_ECHO;
         `RTDC_MODE_CTRL: decode_mode = rtdc_pkg::RTDC_CTRL;
         `RTDC_MODE_AUTO: decode_mode = rtdc_pkg::RTDC_AUTO;
         default:         decode_mode = rtdc_pkg::RTDC_FOUR_WIRE;
      endcase
   endfunction

   // One decode of the scratch write strobe, shared by mode and data paths.
   function automatic logic scratch_hit(input logic       wr,
                                        input logic [2:0] addr);
      scratch_hit = wr && (addr == `RTDC_SCRATCH_OFFSET);
   endfunction

   rtdc_fifo u_tx_fifo (
      .clk       (clk),
      .srst      (srst),
      .enable    (tx_fifo_en),
      .in_valid  (tx_in_valid),
      .in_ready  (tx_in_ready),
      .in_data   (tx_in_data),
      .out_valid (tx_fifo_valid),
      .out_ready (tx_out_ready),
      .out_data  (tx_out_data),
      .level     ()
   );

   rtdc_fifo u_rx_fifo (
      .clk       (clk),
      .srst      (srst),
      .enable    (rx_fifo_en),
      .in_valid  (rx_push_ok),
      .in_ready  (rx_fifo_ready),
      .in_data   (rx_in_data),
      .out_valid (rx_out_valid),
      .out_ready (rx_out_ready),
      .out_data  (rx_out_data),
      .level     (rx_level)
   );

   // Bytes heard while the receiver is disabled never reach the FIFO.
   assign rx_push_ok   = rx_in_valid && st_r.rx_en;
   assign rx_in_ready  = rx_fifo_ready || !st_r.rx_en;
   assign tx_out_valid = tx_fifo_valid;

   // hold through stop bit
   // The shifter flag covers the frame up to the end of its stop bit, so in
   // automatic mode the driver does not drop while the last byte is still on the line.
   assign tx_busy = tx_fifo_valid || tx_shifting;
   assign slot_n  = !tx_busy;
   assign transmit_slot_ready_n = slot_n;

   assign mode_now = scratch_hit(reg_wr, reg_addr)
                     ? decode_mode(reg_wdata) : st_r.mode;

   always_comb begin
      tx_drive = 1'b1;
      rx_open  = 1'b1;
      unique case (mode_now)
         rtdc_pkg::RTDC_FOUR_WIRE: begin
            tx_drive = 1'b1;
            rx_open  = 1'b1;
         end
         rtdc_pkg::RTDC_ECHO: begin
            tx_drive = term_ready_n;
            rx_open  = 1'b1;
         end
         rtdc_pkg::RTDC_CTRL: begin
            tx_drive = term_ready_n;
            rx_open  = !term_ready_n;
         end
         rtdc_pkg::RTDC_AUTO: begin
            tx_drive = !slot_n;
            rx_open  = slot_n;
         end
         default: begin
            tx_drive = 1'b1;
            rx_open  = 1'b1;
         end
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      if (scratch_hit(reg_wr, reg_addr)) begin
         st_nxt.scratch = reg_wdata;
      end
      st_nxt.mode  = mode_now;
      st_nxt.tx_en = tx_drive;
      st_nxt.rx_en = rx_open;
      if (srst) begin
         st_nxt.mode    = rtdc_pkg::RTDC_FOUR_WIRE;
         st_nxt.scratch = `RTDC_MODE_FOUR_WIRE;
         st_nxt.tx_en   = 1'b1;
         st_nxt.rx_en   = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   assign line_tx_en    = st_r.tx_en;
   assign line_rx_en    = st_r.rx_en;
   assign scratch_rdata = st_r.scratch;
   assign mode_state    = st_r.mode;

   a_four_wire_on : assert property (@(posedge clk)
      disable iff (srst)
      st_r.mode == rtdc_pkg::RTDC_FOUR_WIRE |-> line_tx_en && line_rx_en)
      else $error("four-wire mode lost an enable");

   a_echo_drive : assert property (@(posedge clk)
      disable iff (srst)
      $past(mode_now) == rtdc_pkg::RTDC_ECHO && !$past(srst)
      |-> line_tx_en == $past(term_ready_n))
      else $error("echo driver does not follow ready");

   a_echo_rx_on : assert property (@(posedge clk)
      disable iff (srst)
      st_r.mode == rtdc_pkg::RTDC_ECHO |-> line_rx_en)
      else $error("echo receiver disabled");

   a_ctrl_exclusive : assert property (@(posedge clk)
      disable iff (srst)
      st_r.mode == rtdc_pkg::RTDC_CTRL |-> line_tx_en != line_rx_en)
      else $error("controlled mode enables overlap");

   a_auto_drive : assert property (@(posedge clk)
      disable iff (srst)
      $past(mode_now) == rtdc_pkg::RTDC_AUTO && !$past(srst)
      |-> line_tx_en == !$past(transmit_slot_ready_n))
      else $error("automatic driver does not follow slot ready");

   a_auto_exclusive : assert property (@(posedge clk)
      disable iff (srst)
      st_r.mode == rtdc_pkg::RTDC_AUTO |-> line_tx_en != line_rx_en)
      else $error("automatic mode enables overlap");

   a_mode_write : assert property (@(posedge clk)
      disable iff (srst)
      reg_wr && reg_addr == `RTDC_SCRATCH_OFFSET
      && reg_wdata == `RTDC_MODE_CTRL
      |=> mode_state == rtdc_pkg::RTDC_CTRL)
      else $error("mode write not taken");

   a_bad_byte : assert property (@(posedge clk)
      disable iff (srst)
      reg_wr && reg_addr == `RTDC_SCRATCH_OFFSET
      && reg_wdata > `RTDC_MODE_AUTO
      |=> mode_state == rtdc_pkg::RTDC_FOUR_WIRE)
      else $error("unassigned byte not four-wire");

   a_stop_hold : assert property (@(posedge clk)
      disable iff (srst)
      st_r.mode == rtdc_pkg::RTDC_AUTO && $past(mode_now)
      == rtdc_pkg::RTDC_AUTO && $past(tx_shifting) |-> line_tx_en)
      else $error("driver dropped during frame");

   // A pop may still lower the level, but a dropped byte must never raise it.
   a_rx_block : assert property (@(posedge clk)
      disable iff (srst)
      rx_in_valid && !st_r.rx_en |=> rx_level <= $past(rx_level))
      else $error("byte received while receiver off");

   a_reset_mode : assert property (@(posedge clk)
      srst |=> mode_state == rtdc_pkg::RTDC_FOUR_WIRE
      && scratch_rdata == `RTDC_MODE_FOUR_WIRE
      && line_tx_en && line_rx_en)
      else $error("reset did not restore four-wire");

   a_ctrl_drive : assert property (@(posedge clk)
      disable iff (srst)
      $past(mode_now) == rtdc_pkg::RTDC_CTRL && !$past(srst)
      |-> line_tx_en == $past(term_ready_n)
      && line_rx_en == !$past(term_ready_n))
      else $error("controlled mode does not follow ready");

   a_auto_rx_follow : assert property (@(posedge clk)
      disable iff (srst)
      $past(mode_now) == rtdc_pkg::RTDC_AUTO && !$past(srst)
      |-> line_rx_en == $past(transmit_slot_ready_n))
      else $error("automatic receiver does not follow slot ready");

   a_slot_busy : assert property (@(posedge clk)
      disable iff (srst)
      transmit_slot_ready_n == !(tx_out_valid || tx_shifting))
      else $error("slot ready not low while data waits");

   a_scratch_keep : assert property (@(posedge clk)
      disable iff (srst)
      !scratch_hit(reg_wr, reg_addr) |=> $stable(scratch_rdata))
      else $error("scratch changed without a write");

   a_mode_instant : assert property (@(posedge clk)
      disable iff (srst)
      scratch_hit(reg_wr, reg_addr) && reg_wdata == `RTDC_MODE_ECHO
      |=> line_tx_en == $past(term_ready_n) && line_rx_en)
      else $error("echo write not applied at once");

   a_echo_code : assert property (@(posedge clk)
      disable iff (srst)
      scratch_hit(reg_wr, reg_addr) && reg_wdata == `RTDC_MODE_ECHO
      |=> mode_state == rtdc_pkg::RTDC_ECHO)
      else $error("echo byte not decoded");

   a_auto_code : assert property (@(posedge clk)
      disable iff (srst)
      scratch_hit(reg_wr, reg_addr) && reg_wdata == `RTDC_MODE_AUTO
      |=> mode_state == rtdc_pkg::RTDC_AUTO)
      else $error("automatic byte not decoded");

   a_four_code : assert property (@(posedge clk)
      disable iff (srst)
      scratch_hit(reg_wr, reg_addr) && reg_wdata == `RTDC_MODE_FOUR_WIRE
      |=> mode_state == rtdc_pkg::RTDC_FOUR_WIRE)
      else $error("four-wire byte not decoded");

   c_echo_send : cover property (@(posedge clk)
      st_r.mode == rtdc_pkg::RTDC_ECHO && line_tx_en);
   c_ctrl_recv : cover property (@(posedge clk)
      st_r.mode == rtdc_pkg::RTDC_CTRL && line_rx_en && rx_out_valid);
   c_auto_turn : cover property (@(posedge clk)
      st_r.mode == rtdc_pkg::RTDC_AUTO && line_tx_en ##1 line_rx_en);
   c_fifo_full : cover property (@(posedge clk) !tx_in_ready);
   c_reset_auto : cover property (@(posedge clk)
      st_r.mode == rtdc_pkg::RTDC_AUTO ##1 srst);

endmodule

/* File: verif/rtdc_line_model.sv */
// Far-side model: a line shifter that pops the transmit FIFO and the bus
// echo of each sent byte. Assumes the top's FIFO handshakes on one clock.
`timescale 1ns/1ps
module rtdc_line_model #(parameter int FRAME = 10) (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       stall,
   input  wire logic       tx_out_valid,
   output logic            tx_out_ready,
   input  wire logic [7:0] tx_out_data,
   output logic            tx_shifting,
   output logic            rx_in_valid,
   input  wire logic       rx_in_ready,
   output logic [7:0]      rx_in_data
);
   int         cnt_r;
   logic [7:0] byte_r;
   assign tx_out_ready = !stall && cnt_r == 0;
   always @(posedge clk) begin
      if (srst) begin
         cnt_r <= 0;
         tx_shifting <= 1'b0;
         rx_in_valid <= 1'b0;
         rx_in_data <= 8'h5a;
      end else begin
         if (rx_in_valid && rx_in_ready) begin
            rx_in_valid <= 1'b0;
            // A released line must not look like the last byte.
            rx_in_data <= ~rx_in_data;
         end
         if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
            tx_shifting <= cnt_r != 1;
            // The shared pair hands our own byte back as its stop bit starts.
            if (cnt_r == 2) begin
               rx_in_valid <= 1'b1;
               rx_in_data <= byte_r;
            end
         end else if (tx_out_valid && tx_out_ready) begin
            byte_r <= tx_out_data;
            cnt_r <= FRAME;
            tx_shifting <= 1'b1;
         end
      end
   end
endmodule

/* File: verif/tb_rs485_transceiver_direction_control.sv */
// Self-checking bench for the direction control top with its line model.
// Assumes a 40 MHz clock and inputs driven on the falling edge.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_rs485_transceiver_direction_control;
   logic       clk = 0, srst = 1, reg_wr = 0, term_ready_n = 1, stall = 1;
   logic [2:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, tx_in_data = 0, ex;
   logic       tx_fifo_en = 1, rx_fifo_en = 1, tx_in_valid = 0;
   logic       rx_out_ready = 0, echo = 0;
   logic       tx_in_ready, tx_out_valid, tx_out_ready, tx_shifting;
   logic       rx_in_valid, rx_in_ready, rx_out_valid, transmit_slot_ready_n;
   logic       line_tx_en, line_rx_en;
   logic [7:0] tx_out_data, rx_in_data, rx_out_data, scratch_rdata;
   logic [4:0] rx_level;
   logic [3:0] mode_state;
   logic [7:0] txq[$], rxq[$];
   logic [7:0] mb[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h7f};
   int         num_errors = 0, n_tests = 0, seed = 32'h0947;
   always #12.5 clk = ~clk;
   rtdc_top dut (.clk, .srst, .reg_wr, .reg_addr, .reg_wdata, .term_ready_n,
      .tx_fifo_en, .rx_fifo_en, .tx_in_valid, .tx_in_ready, .tx_in_data,
      .tx_out_valid, .tx_out_ready, .tx_out_data, .tx_shifting, .rx_in_valid,
      .rx_in_ready, .rx_in_data, .rx_out_valid, .rx_out_ready, .rx_out_data,
      .rx_level, .transmit_slot_ready_n, .line_tx_en, .line_rx_en,
      .scratch_rdata, .mode_state);
   rtdc_line_model #(.FRAME(10)) line (.clk, .srst, .stall, .tx_out_valid,
      .tx_out_ready, .tx_out_data, .tx_shifting, .rx_in_valid, .rx_in_ready,
      .rx_in_data);
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 0;
   endtask
   task automatic push(input logic [7:0] b);
      tx_in_valid = 1;
      tx_in_data = b;
      txq.push_back(b);
      if (echo) rxq.push_back(b);
      @(negedge clk);
   endtask
   task automatic drain;
      int k;
      for (k = 0; k < 3000 && transmit_slot_ready_n !== 1'b1; k++) begin
         if (tx_shifting === 1'b1) `CHK(line_tx_en, 1'b1)
         @(negedge clk);
      end
      `CHK(transmit_slot_ready_n, 1'b1)
      repeat (3) @(negedge clk);
   endtask
   task print_verdict;
      $display("errors %0d comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(negedge clk) rx_out_ready <= 1'($random(seed));
   // Bytes leaving either FIFO are matched against the oldest note.
   always @(posedge clk) begin
      if (tx_out_valid && tx_out_ready) begin
         ex = txq.size() ? txq.pop_front() : 8'hxx;
         `CHK(tx_out_data, ex)
      end
      if (rx_out_valid && rx_out_ready) begin
         ex = rxq.size() ? rxq.pop_front() : 8'hxx;
         `CHK(rx_out_data, ex)
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      print_verdict();
   end
   initial begin
      logic [7:0] m;
      logic [3:0] em;
      int         i, k;
      repeat (6) @(negedge clk);
      srst = 0;
      `CHK(mode_state, 4'b0001)
      `CHK({line_tx_en, line_rx_en}, 2'b11)
      `CHK(scratch_rdata, 8'h00)
      for (i = 0; i < 10; i++) begin
         m = mb[i/2];
         term_ready_n = i[0];
         wr(3'h7, m);
         @(negedge clk);
         em = m < 4 ? 4'b0001 << m : 4'b0001;
         `CHK(mode_state, em)
         `CHK(scratch_rdata, m)
         `CHK(line_tx_en, em[1] | em[2] ? term_ready_n : !em[3])
         `CHK(line_rx_en, em[2] ? !term_ready_n : 1'b1)
      end
      wr(3'h3, 8'h02);
      @(negedge clk);
      `CHK({mode_state, scratch_rdata}, {4'b0001, 8'h7f})
      for (i = 0; i < 6; i++) begin
         m = 8'(i % 3 + 1);
         term_ready_n = 1;
         wr(3'h7, m);
         echo = m == 1;
         tx_fifo_en = i < 3;
         rx_fifo_en = i < 3;
         stall = 1;
         for (k = 0; k < 20 && tx_in_ready === 1'b1; k++)
            push(8'($random(seed)));
         tx_in_valid = 0;
         `CHK(k, i < 3 ? 16 : 1)
         `CHK(transmit_slot_ready_n, 1'b0)
         stall = 0;
         repeat (3) @(negedge clk);
         if (m == 3) `CHK({line_tx_en, line_rx_en}, 2'b10)
         drain();
         `CHK({line_tx_en, line_rx_en}, m == 3 ? 2'b01 : {1'b1, m == 1})
         term_ready_n = 0;
         repeat (2) @(negedge clk);
         `CHK({line_tx_en, line_rx_en}, 2'b01)
      end
      repeat (60) @(negedge clk);
      `CHK(txq.size() + rxq.size(), 0)
      `CHK(rx_level, 5'h00)
      // A second reset in mid-run must bring back the four-wire state.
      srst = 1;
      repeat (2) @(negedge clk);
      srst = 0;
      `CHK({mode_state, scratch_rdata}, {4'b0001, 8'h00})
      `CHK({line_tx_en, line_rx_en}, 2'b11)
      print_verdict();
   end
endmodule
